// File: hw/mac_irq_pkg.sv
// package: register map, field layout and reset values of the mac interrupt mask block
package mac_irq_pkg;

    // ----------------------------------------------------------------
    // register bus geometry
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned RX_CH  = 8;

    // ----------------------------------------------------------------
    // byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_RX_MASK_SET   = 8'h00;
    localparam logic [7:0] OFS_RX_MASK_CLEAR = 8'h04;
    localparam logic [7:0] OFS_RX_RAW        = 8'h08;
    localparam logic [7:0] OFS_RX_MASKED     = 8'h0C;
    localparam logic [7:0] OFS_MAC_RAW       = 8'h10;
    localparam logic [7:0] OFS_MAC_MASKED    = 8'h14;
    localparam logic [7:0] OFS_MAC_MASK_SET  = 8'h18;
    localparam logic [7:0] OFS_MAC_MASK_CLR  = 8'h1C;
    localparam logic [7:0] OFS_EVT_STATUS    = 8'h20;
    localparam logic [7:0] OFS_EVT_MASK      = 8'h24;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned RX_PEND_LSB   = 0;
    localparam int unsigned RX_PULSE_LSB  = 16;
    localparam int unsigned HOST_ERR_BIT  = 1;
    localparam int unsigned STATS_BIT     = 0;
    localparam logic [7:0]  RX_MASK_RST   = 8'h00;
    localparam logic [1:0]  MAC_MASK_RST  = 2'h0;
    localparam logic [1:0]  EVT_RST       = 2'h0;

endpackage : mac_irq_pkg

// File: hw/w1_mask_bank.sv
// write-one-to-set / write-one-to-clear enable mask bank
module w1_mask_bank #(
    parameter int unsigned        WIDTH = 8,
    parameter logic [WIDTH-1:0]   RST   = '0
) (
    input  wire logic             i_mclk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_set_we,
    input  wire logic             i_clr_we,
    input  wire logic [WIDTH-1:0] i_wdata,
    output logic      [WIDTH-1:0] o_mask
);

    logic [WIDTH-1:0] mask_reg;
    logic [WIDTH-1:0] mask_next;

    // ----------------------------------------------------------------
    // per-bit update: a zero written leaves the bit alone
    // ----------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            assign mask_next[b] = (i_set_we & i_wdata[b]) ? 1'b1 :
                                  (i_clr_we & i_wdata[b]) ? 1'b0 : mask_reg[b];
        end
    endgenerate

    // synchronous reset to the disabled state; every mask starts off
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mask_reg <= RST;
        end else begin
            mask_reg <= mask_next;
        end
    end

    assign o_mask = mask_reg;

endmodule // w1_mask_bank

// File: hw/mac_interrupt_mask_status.sv
// top of the mac interrupt mask and status block with its register port
// How it works
// - A one written to bits 23..16 of the receive mask clear register disables that channel's pulse interrupt.
// - A one written to bits 7..0 of the receive mask clear register disables that channel's pending interrupt.
// - Bit 1 of the mac unmasked status shows the host-error pending state before masking.
// - Bit 0 of the mac unmasked status shows the statistics pending state before masking.
// - Bit 1 of the mac masked status shows the host-error pending state after its mask.
// - Bit 0 of the mac masked status shows the statistics pending state after its mask.
// - A one written to bit 1 of the mac mask set register enables host-error, a zero does nothing.
// - A one written to bit 0 of the mac mask set register enables statistics, a zero does nothing.
// - A one written to bit 1 of the mac mask clear register disables host-error, a zero does nothing.
// - A one written to bit 0 of the mac mask clear register disables statistics, a zero does nothing.
// - A one written to the receive mask set register enables that channel, and all masks reset to zero.
module mac_interrupt_mask_status #(
    parameter int unsigned N_CH = mac_irq_pkg::RX_CH
) (
    input  wire logic                              i_mclk,
    input  wire logic                              i_sys_rst,
    input  wire logic [mac_irq_pkg::ADDR_W-1:0]    i_addr,
    input  wire logic [mac_irq_pkg::DATA_W-1:0]    i_wdata,
    input  wire logic                              i_wr,
    input  wire logic                              i_rd,
    output logic      [mac_irq_pkg::DATA_W-1:0]    o_rdata,
    input  wire logic [N_CH-1:0]                   i_rx_pending,
    input  wire logic [N_CH-1:0]                   i_rx_pulse,
    input  wire logic                              i_host_error_pending,
    input  wire logic                              i_statistics_pending,
    output logic      [N_CH-1:0]                   o_rx_pending_irq,
    output logic      [N_CH-1:0]                   o_rx_pulse_irq,
    output logic                                   o_host_error_irq,
    output logic                                   o_statistics_irq,
    output logic                                   o_irq
);
    import mac_irq_pkg::*;

    // ----------------------------------------------------------------
    // register map, byte offsets of 32-bit words
    // ----------------------------------------------------------------
    // 00 rx mask set: a one enables, reads back the mask
    // 04 rx mask clear: a one disables, reads back the mask
    // 08 rx raw status: pulse in 23:16, pending in 7:0
    // 0C rx masked status: same layout, raw AND mask
    // 10 mac raw status: host error in bit 1, statistics in bit 0
    // 14 mac masked status: same layout, raw AND mask
    // 18 mac mask set: a one enables, reads back the mask
    // 1C mac mask clear: a one disables, reads back the mask
    // 20 event status: sticky, a one written clears a bit
    // 24 event mask: plain read/write
    // writes to read-only or unmapped words are dropped and reads of unmapped
    // words give zero; reads never change state, so a dump of the map is safe

    // ----------------------------------------------------------------
    // timing at the ports
    // ----------------------------------------------------------------
    // a mask write lands on the edge that samples the strobe; every
    // interrupt output is a flop, so it follows its source or its mask
    // one edge later: one cycle of latency buys glitch-free lines
    // read data stand only in the cycle after the read strobe and are
    // zero otherwise, so several slaves can share an or-ed data bus

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // exact compare on every address bit, so no live word has an alias
    wire sel_rx_set  = (i_addr == OFS_RX_MASK_SET);
    wire sel_rx_clr  = (i_addr == OFS_RX_MASK_CLEAR);
    wire sel_rx_raw  = (i_addr == OFS_RX_RAW);
    wire sel_rx_msk  = (i_addr == OFS_RX_MASKED);
    wire sel_mac_raw = (i_addr == OFS_MAC_RAW);
    wire sel_mac_msk = (i_addr == OFS_MAC_MASKED);
    wire sel_mac_set = (i_addr == OFS_MAC_MASK_SET);
    wire sel_mac_clr = (i_addr == OFS_MAC_MASK_CLR);
    wire sel_evt_sts = (i_addr == OFS_EVT_STATUS);
    wire sel_evt_msk = (i_addr == OFS_EVT_MASK);

    // write enables; a read never changes state
    wire we_rx_set  = i_wr & sel_rx_set;
    wire we_rx_clr  = i_wr & sel_rx_clr;
    wire we_mac_set = i_wr & sel_mac_set;
    wire we_mac_clr = i_wr & sel_mac_clr;
    wire we_evt_sts = i_wr & sel_evt_sts;
    wire we_evt_msk = i_wr & sel_evt_msk;

    // ----------------------------------------------------------------
    // mask banks: pulse, pending, mac-level
    // ----------------------------------------------------------------
    logic [N_CH-1:0] rx_pulse_irq_enable;
    logic [N_CH-1:0] rx_pending_irq_enable;
    logic [1:0]      mac_irq_enable;

    // both receive banks share the strobes and differ only in their data slice
    // pulse enables live in the upper half of the receive mask words
    w1_mask_bank #(
        .WIDTH (N_CH),
        .RST   (N_CH'(RX_MASK_RST))
    ) u_rx_pulse_mask (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_set_we  (we_rx_set),
        .i_clr_we  (we_rx_clr),
        .i_wdata   (i_wdata[RX_PULSE_LSB +: N_CH]),
        .o_mask    (rx_pulse_irq_enable)
    );

    // pending enables live in the low byte
    w1_mask_bank #(
        .WIDTH (N_CH),
        .RST   (N_CH'(RX_MASK_RST))
    ) u_rx_pend_mask (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_set_we  (we_rx_set),
        .i_clr_we  (we_rx_clr),
        .i_wdata   (i_wdata[RX_PEND_LSB +: N_CH]),
        .o_mask    (rx_pending_irq_enable)
    );

    // host-error at bit 1, statistics at bit 0; zeros written are ignored
    w1_mask_bank #(
        .WIDTH (2),
        .RST   (MAC_MASK_RST)
    ) u_mac_mask (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_set_we  (we_mac_set),
        .i_clr_we  (we_mac_clr),
        .i_wdata   (i_wdata[1:0]),
        .o_mask    (mac_irq_enable)
    );

    wire host_error_irq_enable = mac_irq_enable[HOST_ERR_BIT];
    wire statistics_irq_enable = mac_irq_enable[STATS_BIT];

    // ----------------------------------------------------------------
    // raw and masked status views
    // ----------------------------------------------------------------
    // raw status comes straight from the event sources, same clock domain
    logic [1:0] mac_raw;
    logic [1:0] mac_masked;
    assign mac_raw[HOST_ERR_BIT]    = i_host_error_pending;
    assign mac_raw[STATS_BIT]       = i_statistics_pending;
    assign mac_masked[HOST_ERR_BIT] = i_host_error_pending & host_error_irq_enable;
    assign mac_masked[STATS_BIT]    = i_statistics_pending & statistics_irq_enable;

    // per-channel masking, one gate per channel and kind
    logic [N_CH-1:0] rx_pend_masked;
    logic [N_CH-1:0] rx_pulse_masked;
    genvar ch;
    generate
        for (ch = 0; ch < N_CH; ch++) begin : g_rx_ch
            assign rx_pend_masked[ch]  = i_rx_pending[ch] & rx_pending_irq_enable[ch];
            assign rx_pulse_masked[ch] = i_rx_pulse[ch] & rx_pulse_irq_enable[ch];
        end
    endgenerate

    // ----------------------------------------------------------------
    // sticky event status and its interrupt line
    // ----------------------------------------------------------------
    // events: rising edge of each masked mac pending line. edge detect so a
    // level that stays high does not re-set the bit after software clears it
    logic [1:0] mac_masked_reg;
    logic [1:0] evt_status_reg;
    logic [1:0] evt_status_next;
    logic [1:0] evt_mask_reg;

    wire [1:0] evt_rise  = mac_masked & ~mac_masked_reg;
    wire [1:0] evt_w1c   = we_evt_sts ? i_wdata[1:0] : 2'h0;
    // set beats clear in the same cycle
    assign evt_status_next = evt_rise | (evt_status_reg & ~evt_w1c);
    // the event mask is a plain read/write word
    logic [1:0] evt_mask_next;
    assign evt_mask_next   = we_evt_msk ? i_wdata[1:0] : evt_mask_reg;
    // limit: a status bit is a flag, not a counter, so a source that falls
    // and rises again before software clears the bit is seen once

    // edge history of the masked mac lines
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mac_masked_reg <= EVT_RST;
        end else begin
            mac_masked_reg <= mac_masked;
        end
    end

    // sticky status: an edge sets a bit, a one written clears it
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            evt_status_reg <= EVT_RST;
        end else begin
            evt_status_reg <= evt_status_next;
        end
    end

    // event mask register
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            evt_mask_reg <= EVT_RST;
        end else begin
            evt_mask_reg <= evt_mask_next;
        end
    end

    // ----------------------------------------------------------------
    // interrupt outputs
    // ----------------------------------------------------------------
    logic [N_CH-1:0] rx_pend_irq_reg;
    logic [N_CH-1:0] rx_pulse_irq_reg;
    logic [1:0]      mac_irq_reg;
    logic            irq_reg;
    logic            irq_next;

    // o_irq looks at the next status, so it rises on the edge that sets the bit
    assign irq_next = |(evt_status_next & evt_mask_reg);

    // registered so outputs are glitch free toward the interrupt fabric
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rx_pend_irq_reg <= '0;
        end else begin
            rx_pend_irq_reg <= rx_pend_masked;
        end
    end

    // receive pulse lines
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rx_pulse_irq_reg <= '0;
        end else begin
            rx_pulse_irq_reg <= rx_pulse_masked;
        end
    end

    // mac lines, host error in bit 1 and statistics in bit 0
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mac_irq_reg <= EVT_RST;
        end else begin
            mac_irq_reg <= mac_masked;
        end
    end

    // the one level line toward the host
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign o_rx_pending_irq = rx_pend_irq_reg;
    assign o_rx_pulse_irq   = rx_pulse_irq_reg;
    assign o_host_error_irq = mac_irq_reg[HOST_ERR_BIT];
    assign o_statistics_irq = mac_irq_reg[STATS_BIT];
    assign o_irq            = irq_reg;

    // ----------------------------------------------------------------
    // read mux; unmapped offsets and reserved bits read zero
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] rx_mask_word;
    logic [DATA_W-1:0] rx_raw_word;
    logic [DATA_W-1:0] rx_msk_word;
    logic [DATA_W-1:0] rdata_next;
    logic [DATA_W-1:0] rdata_reg;

    always_comb begin
        rx_mask_word = '0;
        rx_mask_word[RX_PULSE_LSB +: N_CH] = rx_pulse_irq_enable;
        rx_mask_word[RX_PEND_LSB +: N_CH]  = rx_pending_irq_enable;
        rx_raw_word  = '0;
        rx_raw_word[RX_PULSE_LSB +: N_CH]  = i_rx_pulse;
        rx_raw_word[RX_PEND_LSB +: N_CH]   = i_rx_pending;
        rx_msk_word  = '0;
        rx_msk_word[RX_PULSE_LSB +: N_CH]  = rx_pulse_masked;
        rx_msk_word[RX_PEND_LSB +: N_CH]   = rx_pend_masked;
    end

    // the two-bit words, zero-extended to the bus width
    wire [DATA_W-1:0] mac_raw_word  = {30'h0, mac_raw};
    wire [DATA_W-1:0] mac_msk_word  = {30'h0, mac_masked};
    wire [DATA_W-1:0] mac_mask_word = {30'h0, mac_irq_enable};
    wire [DATA_W-1:0] evt_sts_word  = {30'h0, evt_status_reg};
    wire [DATA_W-1:0] evt_msk_word  = {30'h0, evt_mask_reg};

    // set and clear addresses both read back the live mask
    assign rdata_next =
        (sel_rx_set | sel_rx_clr)   ? rx_mask_word :
        sel_rx_raw                  ? rx_raw_word :
        sel_rx_msk                  ? rx_msk_word :
        sel_mac_raw                 ? mac_raw_word :
        sel_mac_msk                 ? mac_msk_word :
        (sel_mac_set | sel_mac_clr) ? mac_mask_word :
        sel_evt_sts                 ? evt_sts_word :
        sel_evt_msk                 ? evt_msk_word : 32'h0;

    // read data valid only in the cycle after the strobe
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= i_rd ? rdata_next : 32'h0;
        end
    end

    assign o_rdata = rdata_reg;

endmodule // mac_interrupt_mask_status

// File: dv/mac_interrupt_mask_status_sva.sv
// checker: port-level properties of the mac interrupt mask and status block
module mac_interrupt_mask_status_sva #(
    parameter int unsigned N_CH = mac_irq_pkg::RX_CH
) (
    input wire logic                           i_mclk,
    input wire logic                           i_sys_rst,
    input wire logic [mac_irq_pkg::ADDR_W-1:0] i_addr,
    input wire logic [mac_irq_pkg::DATA_W-1:0] i_wdata,
    input wire logic                           i_wr,
    input wire logic                           i_rd,
    input wire logic [mac_irq_pkg::DATA_W-1:0] o_rdata,
    input wire logic [N_CH-1:0]                i_rx_pending,
    input wire logic [N_CH-1:0]                i_rx_pulse,
    input wire logic                           i_host_error_pending,
    input wire logic                           i_statistics_pending,
    input wire logic [N_CH-1:0]                o_rx_pending_irq,
    input wire logic [N_CH-1:0]                o_rx_pulse_irq,
    input wire logic                           o_host_error_irq,
    input wire logic                           o_statistics_irq,
    input wire logic                           o_irq
);
    import mac_irq_pkg::*;
    // write-data slices; $past needs a plain signal
    wire logic [N_CH-1:0] wr_pend  = i_wdata[RX_PEND_LSB +: N_CH];
    wire logic [N_CH-1:0] wr_pulse = i_wdata[RX_PULSE_LSB +: N_CH];
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // a clear lands at the write edge; the registered output follows one edge later
    AST_RX_PEND_CLR: assert property (i_wr && i_addr == OFS_RX_MASK_CLEAR |=> ##1
        (o_rx_pending_irq & $past(wr_pend, 2)) == '0) else $error("rx pending irq after clear");
    AST_RX_PULSE_CLR: assert property (i_wr && i_addr == OFS_RX_MASK_CLEAR |=> ##1
        (o_rx_pulse_irq & $past(wr_pulse, 2)) == '0) else $error("rx pulse irq after clear");
    AST_MAC_RAW_RD: assert property (i_rd && i_addr == OFS_MAC_RAW |=>
        o_rdata == {30'h0, $past(i_host_error_pending), $past(i_statistics_pending)})
        else $error("mac raw status read wrong");
    // the masked word read and the registered mac lines see the same cycle
    AST_MAC_MASKED_RD: assert property (i_rd && i_addr == OFS_MAC_MASKED |=>
        o_rdata == {30'h0, o_host_error_irq, o_statistics_irq})
        else $error("mac masked status read wrong");
    AST_HOST_SET: assert property ((i_wr && i_addr == OFS_MAC_MASK_SET && i_wdata[1])
        ##1 i_host_error_pending |=> o_host_error_irq) else $error("host irq not enabled");
    AST_STAT_SET: assert property ((i_wr && i_addr == OFS_MAC_MASK_SET && i_wdata[0])
        ##1 i_statistics_pending |=> o_statistics_irq) else $error("stats irq not enabled");
    AST_HOST_CLR: assert property (i_wr && i_addr == OFS_MAC_MASK_CLR && i_wdata[1]
        |=> ##1 !o_host_error_irq) else $error("host irq not disabled");
    AST_STAT_CLR: assert property (i_wr && i_addr == OFS_MAC_MASK_CLR && i_wdata[0]
        |=> ##1 !o_statistics_irq) else $error("stats irq not disabled");
    AST_MASKED_SUBSET: assert property (((o_rx_pending_irq & ~$past(i_rx_pending))
        | (o_rx_pulse_irq & ~$past(i_rx_pulse))) == '0 && (!o_host_error_irq ||
        $past(i_host_error_pending)) && (!o_statistics_irq || $past(i_statistics_pending)))
        else $error("masked irq without raw source");
    AST_RD_IDLE: assert property (!i_rd |=> o_rdata == '0) else $error("read data not idle");
endmodule // mac_interrupt_mask_status_sva

bind mac_interrupt_mask_status mac_interrupt_mask_status_sva #(.N_CH(N_CH)) sva_u (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_pending(i_rx_pending), .i_rx_pulse(i_rx_pulse),
    .i_host_error_pending(i_host_error_pending), .i_statistics_pending(i_statistics_pending),
    .o_rx_pending_irq(o_rx_pending_irq), .o_rx_pulse_irq(o_rx_pulse_irq),
    .o_host_error_irq(o_host_error_irq), .o_statistics_irq(o_statistics_irq), .o_irq(o_irq));

// File: dv/test_mac_interrupt_mask_status.sv
// testbench: random and corner register traffic against the mac interrupt mask block
module test_mac_interrupt_mask_status import mac_irq_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic              i_mclk = 1'b0;
    logic              i_sys_rst = 1'b1;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0, o_rdata, q;
    logic              i_wr = 1'b0, i_rd = 1'b0, o_host_error_irq, o_statistics_irq, o_irq;
    logic [RX_CH-1:0]  i_rx_pending = '0, i_rx_pulse = '0, o_rx_pending_irq, o_rx_pulse_irq;
    logic              i_host_error_pending = 1'b0, i_statistics_pending = 1'b0;
    logic [15:0]       rx_mask = '0; // bench copy: pulse in 15:8, pending in 7:0
    logic [1:0]        mac_mask = '0;
    logic [31:0]       seed = 32'h46;
    logic [7:0]        ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h40};
    logic [7:0]        wofs [4] = '{8'h00, 8'h04, 8'h18, 8'h1C};
    int                miscompares = 0, n_tests = 0;

    mac_interrupt_mask_status #(.N_CH(RX_CH)) dut_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_rx_pending(i_rx_pending), .i_rx_pulse(i_rx_pulse), .o_irq(o_irq),
        .i_host_error_pending(i_host_error_pending), .i_statistics_pending(i_statistics_pending),
        .o_rx_pending_irq(o_rx_pending_irq), .o_rx_pulse_irq(o_rx_pulse_irq),
        .o_host_error_irq(o_host_error_irq), .o_statistics_irq(o_statistics_irq));

    // 125 MHz clock
    always #4 i_mclk = ~i_mclk;

    // ----------------------------------------------------------------
    // expectation helpers and bus tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    function automatic logic [31:0] rx_word(input logic [15:0] v);
        return {8'h00, v[15:8], 8'h00, v[7:0]};
    endfunction
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h00, 8'h04: return rx_word(rx_mask);
            8'h08: return rx_word({i_rx_pulse, i_rx_pending});
            8'h0C: return rx_word({i_rx_pulse, i_rx_pending} & rx_mask);
            8'h10: return {30'h0, i_host_error_pending, i_statistics_pending};
            8'h14: return {30'h0, {i_host_error_pending, i_statistics_pending} & mac_mask};
            8'h18, 8'h1C: return {30'h0, mac_mask};
            default: return 32'h0; // unmapped reads give zero
        endcase
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // the rx and mac registers (not the event words) and one unmapped offset, plus the rx and mac interrupt outputs, against the bench copy of the masks
    task automatic check_regs();
        logic [31:0] v;
        foreach (ofs[k]) begin
            rd(ofs[k], v);
            chk("rdata", exp_rd(ofs[k]), v);
        end
        chk("rx_irq", {16'h0, {i_rx_pulse, i_rx_pending} & rx_mask},
            {16'h0, o_rx_pulse_irq, o_rx_pending_irq});
        chk("mac_irq", {30'h0, {i_host_error_pending, i_statistics_pending} & mac_mask},
            {30'h0, o_host_error_irq, o_statistics_irq});
    endtask
    task automatic end_sim();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence: reset values, random set/clear traffic, interrupt path
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        check_regs();
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            q = (i < 4) ? 32'hFFFFFFFF : (i < 8) ? 32'h0 : seed; // all ones, then zero writes
            wr(wofs[i % 4], q);
            case (i % 4)
                0: rx_mask = rx_mask | {q[23:16], q[7:0]};
                1: rx_mask = rx_mask & ~{q[23:16], q[7:0]};
                2: mac_mask = mac_mask | q[1:0];
                default: mac_mask = mac_mask & ~q[1:0];
            endcase
            seed = lfsr(seed);
            {i_rx_pulse, i_rx_pending, i_host_error_pending, i_statistics_pending} <= seed[17:0];
            repeat (2) @(posedge i_mclk);
            check_regs();
        end
        @(posedge i_mclk);
        {i_host_error_pending, i_statistics_pending} <= 2'h0;
        wr(8'h1C, 32'h3);
        wr(OFS_EVT_STATUS, 32'h3);
        wr(OFS_EVT_MASK, 32'h3);
        wr(8'h18, 32'h3);
        {i_host_error_pending, i_statistics_pending} <= 2'h3;
        repeat (3) @(posedge i_mclk);
        #1 chk("irq", 32'h1, 32'(o_irq));
        rd(OFS_EVT_STATUS, q);
        chk("evt_status", 32'h3, q);
        // the source stays high, so a cleared event must not come back
        wr(OFS_EVT_STATUS, 32'h3);
        repeat (2) @(posedge i_mclk);
        #1 chk("irq", 32'h0, 32'(o_irq));
        wr(OFS_EVT_MASK, 32'h0);
        wr(8'h1C, 32'h3);
        repeat (2) @(posedge i_mclk);
        #1 chk("mac_irq", 32'h0, {30'h0, o_host_error_irq, o_statistics_irq});
        wr(8'h18, 32'h3);
        repeat (3) @(posedge i_mclk);
        #1 chk("mac_irq", 32'h3, {30'h0, o_host_error_irq, o_statistics_irq});
        chk("irq", 32'h0, 32'(o_irq));
        wr(OFS_EVT_MASK, 32'h3);
        repeat (2) @(posedge i_mclk);
        #1 chk("irq", 32'h1, 32'(o_irq));
        end_sim();
    end

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge i_mclk);
        miscompares++;
        end_sim();
    end
endmodule // test_mac_interrupt_mask_status
